/* core/fcs_cond_save_core.sv */
/*
 * condition evaluation, exception flags, overlapped command queue and
 * state save/restore of the floating-point coprocessor, behind apb.
 * assumes an apb master on pclk; the frame pointer steps itself on each frame access while no save or restore runs.
 */
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module fcs_cond_save_core
  import fcs_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  // ****************************************
  // bus decode
  // ****************************************
  function automatic logic fcs_mapped(input logic [7:0] a);
    logic ok;
    if (a == ADDR_CTRL || a == ADDR_STAT || a == ADDR_IADDR) begin
      ok = 1'b1;
    end else if (a == ADDR_COND || a == ADDR_RESP || a == ADDR_CMD) begin
      ok = 1'b1;
    end else if (a == ADDR_FRAME || a == ADDR_FPTR) begin
      ok = 1'b1;
    end else begin
      ok = 1'b0;
    end
    return ok;
  endfunction : fcs_mapped

  fcs_regs_t   r_q;
  fcs_regs_t   r_d;
  logic        wr_go;
  logic        rd_go;
  logic        stat_wr;
  logic        cond_wr;
  logic        cmd_wr;
  logic        retire;
  logic        eval_fire;
  logic        mem_we;
  logic [3:0]  mem_waddr;
  logic [31:0] mem_wdata;
  logic [3:0]  mem_raddr;
  logic [31:0] mem_rdata;
  logic [31:0] stat_view;
  logic [31:0] resp_view;
  logic [1:0]  kind;

  assign pready    = psel & penable & r_q.ack;
  assign pslverr   = pready & !fcs_mapped(paddr);
  assign prdata    = r_q.prdata;
  assign wr_go     = pready & pwrite & fcs_mapped(paddr);
  assign rd_go     = pready & !pwrite;
  assign stat_wr   = wr_go && paddr == ADDR_STAT;
  assign cond_wr   = wr_go && paddr == ADDR_COND;
  assign cmd_wr    = wr_go && paddr == ADDR_CMD;
  assign kind      = pwdata[1:0];
  assign retire    = r_q.v0 && r_q.n0 == 4'h0;
  // conditions wait until older commands have delivered their codes
  assign eval_fire = r_q.cond_pend && !r_q.v0 && r_q.st == ST_IDLE;
  assign mem_raddr = (r_q.st == ST_IDLE) ? r_q.ptr : r_q.idx;
  assign stat_view = {4'h0, r_q.cc, 8'h00, r_q.exc, 8'h00};
  assign resp_view = {27'h0, r_q.st != ST_IDLE, r_q.refused, r_q.v1,
                      r_q.cond_true, r_q.resp_valid};

  fcs_frame_mem u_mem (
    .clk   (pclk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    r_d       = r_q;
    mem_we    = 1'b0;
    mem_waddr = r_q.ptr;
    mem_wdata = pwdata;
    r_d.ack   = psel & penable & !r_q.ack;

    // read data captured in the first access cycle
    if (psel && penable && !r_q.ack && !pwrite) begin
      if (paddr == ADDR_CTRL) begin
        r_d.prdata = r_q.ctrl;
      end else if (paddr == ADDR_STAT) begin
        r_d.prdata = stat_view;
      end else if (paddr == ADDR_IADDR) begin
        r_d.prdata = r_q.iaddr;
      end else if (paddr == ADDR_RESP) begin
        r_d.prdata = resp_view;
      end else if (paddr == ADDR_CMD) begin
        r_d.prdata = r_q.cmd;
      end else if (paddr == ADDR_FRAME) begin
        r_d.prdata = mem_rdata;
      end else if (paddr == ADDR_FPTR) begin
        r_d.prdata = {28'h0, r_q.ptr};
      end else begin
        r_d.prdata = 32'h0000_0000;
      end
    end

    // software moves to the control set
    if (wr_go && paddr == ADDR_CTRL) begin
      r_d.ctrl = pwdata;
    end
    if (wr_go && paddr == ADDR_IADDR) begin
      r_d.iaddr = pwdata;
    end
    if (stat_wr) begin
      r_d.cc  = pwdata[STAT_CC_LSB +: 4];
      r_d.exc = pwdata[STAT_EXC_LSB +: 8];
    end
    if (wr_go && paddr == ADDR_FPTR) begin
      r_d.ptr = pwdata[3:0];
    end
    if (wr_go && paddr == ADDR_FRAME && r_q.st == ST_IDLE) begin
      mem_we  = 1'b1;
      r_d.ptr = r_q.ptr + 4'h1;
    end
    if (rd_go && paddr == ADDR_FRAME && r_q.st == ST_IDLE) begin
      r_d.ptr = r_q.ptr + 4'h1;
    end

    // two overlapped commands, retired strictly in issue order
    if (r_q.v0 && r_q.n0 != 4'h0) begin
      r_d.n0 = r_q.n0 - 4'h1;
    end
    if (r_q.v1 && r_q.n1 != 4'h0) begin
      r_d.n1 = r_q.n1 - 4'h1;
    end
    if (retire) begin
      r_d.cc       = r_q.c0;
      r_d.exc[6:0] = r_d.exc[6:0] | r_q.x0;
      r_d.v0       = r_q.v1;
      r_d.n0       = r_d.n1;
      r_d.x0       = r_q.x1;
      r_d.c0       = r_q.c1;
      r_d.v1       = 1'b0;
    end

    // predicate evaluation against settled codes
    if (eval_fire) begin
      r_d.cond_true  = fcs_pred_eval(r_q.pred, r_q.cc);
      r_d.resp_valid = 1'b1;
      r_d.cond_pend  = 1'b0;
      if (r_q.pred[PRED_SIG_BIT] && r_q.cc[CC_NAN]) begin
        r_d.exc[EXC_UNORD] = 1'b1;
      end
    end
    if (cond_wr) begin
      r_d.pred       = pwdata[4:0];
      r_d.cond_pend  = 1'b1;
      r_d.resp_valid = 1'b0;
    end

    // command word decides all execution
    if (cmd_wr) begin
      r_d.cmd = pwdata;
      if (kind == KIND_ARITH && !r_q.v1 && r_q.st == ST_IDLE) begin
        if (!r_d.v0) begin
          r_d.v0 = 1'b1;
          r_d.n0 = pwdata[CMD_LAT_LSB +: 4];
          r_d.x0 = pwdata[CMD_EXC_LSB +: 7];
          r_d.c0 = pwdata[CMD_CC_LSB +: 4];
        end else begin
          r_d.v1 = 1'b1;
          r_d.n1 = pwdata[CMD_LAT_LSB +: 4];
          r_d.x1 = pwdata[CMD_EXC_LSB +: 7];
          r_d.c1 = pwdata[CMD_CC_LSB +: 4];
        end
      end else if (kind == KIND_SAVE && !r_q.v0 && r_q.st == ST_IDLE) begin
        r_d.st  = ST_SAVE;
        r_d.idx = 4'h0;
      end else if (kind == KIND_REST && !r_q.v0 && r_q.st == ST_IDLE) begin
        r_d.st      = ST_REST;
        r_d.idx     = 4'h0;
        r_d.refused = 1'b0;
      end
    end

    case (r_q.st)
      ST_SAVE: begin
        mem_we    = 1'b1;
        mem_waddr = r_q.idx;
        if (r_q.idx == 4'h0) begin
          mem_wdata = FMT_WORD;
        end else if (r_q.idx == FRM_CTRL) begin
          mem_wdata = r_q.ctrl;
        end else if (r_q.idx == FRM_STAT) begin
          mem_wdata = stat_view;
        end else if (r_q.idx == FRM_IADDR) begin
          mem_wdata = r_q.iaddr;
        end else begin
          mem_wdata = 32'h0000_0000;
        end
        r_d.idx = r_q.idx + 4'h1;
        if (r_q.idx == FRAME_LAST_IDX) begin
          r_d.st  = ST_IDLE;
          r_d.ptr = 4'h0;
        end
      end
      ST_REST: begin
        // data of word idx-1 arrives while idx is presented
        r_d.idx = r_q.idx + 4'h1;
        if (r_q.idx == 4'h1 && mem_rdata[31:24] != FMT_ID_THIS) begin
          r_d.refused = 1'b1;
          r_d.st      = ST_IDLE;
          r_d.ptr     = 4'h0;
        end else if (r_q.idx == 4'h2) begin
          r_d.ctrl = mem_rdata;
        end else if (r_q.idx == 4'h3) begin
          r_d.cc  = mem_rdata[STAT_CC_LSB +: 4];
          r_d.exc = mem_rdata[STAT_EXC_LSB +: 8];
        end else if (r_q.idx == 4'h4) begin
          r_d.iaddr = mem_rdata;
          r_d.st    = ST_IDLE;
          r_d.ptr   = 4'h0;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q       <= '0;
      r_q.st    <= ST_IDLE;
      r_q.ctrl  <= CTRL_RST;
      r_q.iaddr <= IADDR_RST;
      r_q.cc    <= CC_RST;
      r_q.exc   <= EXC_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_cond_take;
    cond_wr && !r_q.v0 && r_q.st == ST_IDLE && !cmd_wr;
  endsequence

  sequence s_answer;
    ##1 r_q.cond_pend ##1 r_q.resp_valid;
  endsequence

  property p_cond_resp;
    s_cond_take |-> s_answer;
  endproperty
  a_cond_resp: assert property (p_cond_resp) else $error("condition not answered");

  property p_pred_sel;
    cond_wr |=> r_q.pred == $past(pwdata[4:0]);
  endproperty
  a_pred_sel: assert property (p_pred_sel) else $error("predicate not captured");

  property p_nonsig_quiet;
    eval_fire && !r_q.pred[PRED_SIG_BIT] && !stat_wr && !r_q.exc[EXC_UNORD]
      |=> !r_q.exc[EXC_UNORD];
  endproperty
  a_nonsig_quiet: assert property (p_nonsig_quiet) else $error("quiet test set flag");

  property p_sig_flag;
    eval_fire && r_q.pred[PRED_SIG_BIT] && r_q.cc[CC_NAN] |=> r_q.exc[EXC_UNORD];
  endproperty
  a_sig_flag: assert property (p_sig_flag) else $error("signaling test missed flag");

  property p_unord_true;
    eval_fire && r_q.cc[CC_NAN] && r_q.pred[3:0] >= 4'h8 && r_q.pred[3:0] <= 4'hd
      |=> r_q.cond_true && r_q.resp_valid;
  endproperty
  a_unord_true: assert property (p_unord_true) else $error("unordered variant false");

  property p_unrel;
    eval_fire && r_q.pred == PRED_UNREL |=> r_q.cond_true == $past(r_q.cc[CC_NAN]);
  endproperty
  a_unrel: assert property (p_unrel) else $error("negated test wrong");

  property p_in_order;
    !(r_q.v1 && !r_q.v0);
  endproperty
  a_in_order: assert property (p_in_order) else $error("queue out of order");

  property p_save_len;
    r_q.st == ST_IDLE ##1 r_q.st == ST_SAVE |-> ##14 r_q.st == ST_SAVE ##1 r_q.st == ST_IDLE;
  endproperty
  a_save_len: assert property (p_save_len) else $error("frame length wrong");

  sequence s_bad_fmt;
    r_q.st == ST_REST && r_q.idx == 4'h1 && mem_rdata[31:24] != FMT_ID_THIS;
  endsequence

  property p_refuse;
    s_bad_fmt |=> r_q.refused && r_q.st == ST_IDLE && $stable(r_q.ctrl);
  endproperty
  a_refuse: assert property (p_refuse) else $error("foreign frame taken");

  property p_sticky;
    r_q.exc[EXC_UNORD] && !stat_wr && r_q.st != ST_REST |=> r_q.exc[EXC_UNORD];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");

endmodule : fcs_cond_save_core

`default_nettype wire

/* core/fcs_frame_mem.sv */
/*
 * state frame store: one write port, one registered read port.
 * assumes addresses and write data from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module fcs_frame_mem
  import fcs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        we,
  input  wire logic [3:0]  waddr,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  raddr,
  output var  logic [31:0] rdata
);

  logic [31:0] mem [16];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : fcs_frame_mem

`default_nettype wire

/* core/fcs_pkg.sv */
/*
 * constants, types and the predicate decoder of the floating-point
 * condition and state-save block.
 * assumes a 32-bit apb master on the same clock as the block.
 */

package fcs_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [7:0] ADDR_IADDR = 8'h08;
  localparam logic [7:0] ADDR_COND  = 8'h0c;
  localparam logic [7:0] ADDR_RESP  = 8'h10;
  localparam logic [7:0] ADDR_CMD   = 8'h14;
  localparam logic [7:0] ADDR_FRAME = 8'h18;
  localparam logic [7:0] ADDR_FPTR  = 8'h1c;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int STAT_CC_LSB  = 24;
  localparam int STAT_EXC_LSB = 8;
  localparam int CC_NAN       = 0;
  localparam int CC_Z         = 2;
  localparam int CC_N         = 3;
  localparam int EXC_UNORD    = 7;
  localparam int CMD_LAT_LSB  = 4;
  localparam int CMD_EXC_LSB  = 8;
  localparam int CMD_CC_LSB   = 20;
  localparam int RESP_VALID   = 0;
  localparam int RESP_TRUE    = 1;
  localparam int RESP_FULL    = 2;
  localparam int RESP_REFUSED = 3;
  localparam int RESP_BUSY    = 4;
  localparam int PRED_SIG_BIT = 4;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] IADDR_RST = 32'h0000_0000;
  localparam logic [3:0]  CC_RST    = 4'h0;
  localparam logic [7:0]  EXC_RST   = 8'h00;

  // ****************************************
  // commands and predicates
  // ****************************************
  localparam logic [1:0] KIND_NOP   = 2'h0;
  localparam logic [1:0] KIND_ARITH = 2'h1;
  localparam logic [1:0] KIND_SAVE  = 2'h2;
  localparam logic [1:0] KIND_REST  = 2'h3;
  localparam logic [4:0] PRED_UNREL = 5'h18;

  // ****************************************
  // state frame layout
  // ****************************************
  localparam int PRED_IDLE_BYTES = 28;
  localparam int GROWTH_BYTES    = 32;
  localparam int IDLE_BYTES      = PRED_IDLE_BYTES + GROWTH_BYTES;
  localparam int PRED_FLAG_OFS   = 24;
  localparam int FLAG_OFS        = PRED_FLAG_OFS + GROWTH_BYTES;
  localparam logic [3:0] FRAME_LAST_IDX = 4'(IDLE_BYTES / 4 - 1);
  localparam logic [3:0] FLAG_IDX       = 4'(FLAG_OFS / 4);
  localparam logic [3:0] FRM_CTRL  = 4'h1;
  localparam logic [3:0] FRM_STAT  = 4'h2;
  localparam logic [3:0] FRM_IADDR = 4'h3;
  // format identities: arbitrary values
  localparam logic [7:0] FMT_ID_THIS = 8'h2a;
  localparam logic [7:0] FMT_ID_PRED = 8'h1f;
  localparam logic [31:0] FMT_WORD = {FMT_ID_THIS, 8'(IDLE_BYTES), 16'h0000};

  typedef enum logic [1:0] {ST_IDLE, ST_SAVE, ST_REST} fcs_state_t;

  typedef struct packed {
    fcs_state_t  st;
    logic        ack;
    logic [31:0] prdata;
    logic [31:0] ctrl;
    logic [31:0] iaddr;
    logic [31:0] cmd;
    logic [3:0]  cc;
    logic [7:0]  exc;
    logic [4:0]  pred;
    logic        cond_pend;
    logic        resp_valid;
    logic        cond_true;
    logic        refused;
    logic [3:0]  idx;
    logic [3:0]  ptr;
    logic        v0;
    logic        v1;
    logic [3:0]  n0;
    logic [3:0]  n1;
    logic [6:0]  x0;
    logic [6:0]  x1;
    logic [3:0]  c0;
    logic [3:0]  c1;
  } fcs_regs_t;

  // predicate against condition codes n, z, nan
  function automatic logic fcs_pred_eval(input logic [4:0] p, input logic [3:0] cc);
    logic n;
    logic z;
    logic u;
    logic r;
    n = cc[CC_N];
    z = cc[CC_Z];
    u = cc[CC_NAN];
    case (p[3:0])
      4'h0: r = 1'b0;
      4'h1: r = z;
      4'h2: r = !(u | z | n);
      4'h3: r = z | !(u | n);
      4'h4: r = n & !(u | z);
      4'h5: r = z | (n & !u);
      4'h6: r = !(u | z);
      4'h7: r = !u;
      4'h8: r = u;
      4'h9: r = u | z;
      4'ha: r = u | !(n | z);
      4'hb: r = u | z | !n;
      4'hc: r = u | (n & !z);
      4'hd: r = u | z | n;
      4'he: r = !z;
      default: r = 1'b1;
    endcase
    return r;
  endfunction : fcs_pred_eval

endpackage : fcs_pkg

/* sim/fcs_cond_save_core_test.sv */
/*
 * self-checking bench: predicates, unordered flag, command queue,
 * state save and restore of the condition and state-save block.
 * assumes the host model drives psel, penable, pwrite, paddr and pwdata; the bench drives pclk and presetn.
 */
`timescale 1ns/1ps
`default_nettype none

module fcs_cond_save_core_test
  import fcs_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          fail_count;
  int          checks_done;
  logic [3:0]  cc;
  logic        sticky;
  logic [4:0]  p;
  logic [31:0] v;
  logic [31:0] rc;
  logic [31:0] ri;
  logic        er;
  logic [31:0] fr [15];

  fcs_cond_save_core fcs_cond_save_core_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  fcs_host_model fcs_host_model_i (
    .pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic exp_pred(input logic [4:0] q, input logic [3:0] c);
    logic u;
    logic eq;
    logic lt;
    logic gt;
    u  = c[CC_NAN];
    eq = c[CC_Z] & !u;
    lt = c[CC_N] & !u & !c[CC_Z];
    gt = !u & !c[CC_Z] & !c[CC_N];
    return (q[3] & u) | (q[2] & lt) | (q[1] & gt) | (q[0] & eq);
  endfunction : exp_pred

  function automatic logic [31:0] arith(input logic [3:0] lat, input logic [6:0] x,
                                        input logic [3:0] c);
    return {8'h00, c, 5'h00, x, lat, 2'b00, KIND_ARITH};
  endfunction : arith

  task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    fcs_host_model_i.xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    fcs_host_model_i.xfer(1'b0, a, 32'h0, d, e);
  endtask : rd

  task automatic poll(input int b, input logic lvl);
    logic [31:0] r;
    int          n;
    n = 0;
    rd(ADDR_RESP, r);
    while (r[b] !== lvl && n < 100) begin
      rd(ADDR_RESP, r);
      n++;
    end
    chk("resp bit", {31'h0, lvl}, {31'h0, r[b]});
  endtask : poll

  task automatic final_report();
    $display("mismatches %0d checks %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  initial begin
    #(40 * 20000);
    fail_count++;
    final_report();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    fail_count  = 0;
    checks_done = 0;
    presetn     = 1'b0;
    sticky      = 1'b0;
    cc          = 4'h0;
    void'($urandom(89));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CTRL, v);
    chk("ctrl reset", CTRL_RST, v);
    rd(ADDR_STAT, v);
    chk("stat reset", 32'h0, v);
    fcs_host_model_i.xfer(1'b0, 8'h20, 32'h0, v, er);
    chk("unmapped err", 32'h1, {31'h0, er});
    for (int i = 0; i < 64; i++) begin
      p = (i < 32) ? 5'(i) : 5'($urandom_range(0, 31));
      if (i == 0 || $urandom_range(0, 2) != 0) begin
        cc = $urandom_range(0, 1) ? 4'h1 : {2'($urandom), 1'($urandom), 1'b0};
        wr(ADDR_STAT, {4'h0, cc, 24'h0});
        sticky = 1'b0;
      end
      wr(ADDR_COND, {27'h0, p});
      poll(RESP_VALID, 1'b1);
      rd(ADDR_RESP, v);
      chk("cond true", {31'h0, exp_pred(p, cc)}, {31'h0, v[RESP_TRUE]});
      sticky = sticky | (p[4] & cc[CC_NAN]);
      rd(ADDR_STAT, v);
      chk("unordered flag", {31'h0, sticky}, {31'h0, v[STAT_EXC_LSB + EXC_UNORD]});
    end
    wr(ADDR_STAT, {4'h0, 4'h1, 24'h0});
    wr(ADDR_COND, {27'h0, PRED_UNREL});
    poll(RESP_VALID, 1'b1);
    rd(ADDR_RESP, v);
    chk("negated relation on nan", 32'h1, {31'h0, v[RESP_TRUE]});
    wr(ADDR_STAT, 32'h0);
    wr(ADDR_CMD, arith(4'hf, 7'h01, 4'h8));
    wr(ADDR_CMD, arith(4'h0, 7'h02, 4'h4));
    wr(ADDR_CMD, arith(4'h0, 7'h04, 4'h1));
    rd(ADDR_RESP, v);
    chk("queue full", 32'h1, {31'h0, v[RESP_FULL]});
    wr(ADDR_COND, {27'h0, 5'h01});
    poll(RESP_VALID, 1'b1);
    rd(ADDR_RESP, v);
    chk("in order cc", 32'h1, {31'h0, v[RESP_TRUE]});
    rd(ADDR_STAT, v);
    chk("retired exc", 32'h03, {25'h0, v[14:8]});
    rc = $urandom;
    ri = $urandom;
    wr(ADDR_CTRL, rc);
    wr(ADDR_IADDR, ri);
    wr(ADDR_CMD, {30'h0, KIND_SAVE});
    poll(RESP_BUSY, 1'b0);
    wr(ADDR_FPTR, 32'h0);
    for (int i = 0; i < 15; i++) begin
      rd(ADDR_FRAME, fr[i]);
    end
    chk("format id", {24'h0, FMT_ID_THIS}, {24'h0, fr[0][31:24]});
    chk("frame size", 32'(PRED_IDLE_BYTES + 32), {24'h0, fr[0][23:16]});
    chk("saved ctrl", rc, fr[1]);
    chk("saved iaddr", ri, fr[3]);
    wr(ADDR_FPTR, 32'((PRED_FLAG_OFS + 32) / 4));
    wr(ADDR_FRAME, fr[14] | 32'h0800_0000);
    wr(ADDR_CTRL, ~rc);
    wr(ADDR_CMD, {30'h0, KIND_REST});
    poll(RESP_BUSY, 1'b0);
    rd(ADDR_RESP, v);
    chk("own frame", 32'h0, {31'h0, v[RESP_REFUSED]});
    rd(ADDR_CTRL, v);
    chk("restored ctrl", rc, v);
    wr(ADDR_FPTR, 32'h0);
    wr(ADDR_FRAME, {FMT_ID_PRED, 8'(PRED_IDLE_BYTES), 16'h0});
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CMD, {30'h0, KIND_REST});
    poll(RESP_BUSY, 1'b0);
    rd(ADDR_RESP, v);
    chk("foreign frame", 32'h1, {31'h0, v[RESP_REFUSED]});
    rd(ADDR_CTRL, v);
    chk("ctrl kept", 32'h0, v);
    final_report();
  end
endmodule : fcs_cond_save_core_test

`default_nettype wire

/* sim/fcs_host_model.sv */
/*
 * host processor model: an apb master that moves command words and
 * register values; the slave steps the frame pointer after each frame access made while no save or restore runs.
 * assumes pclk and the slave's pready, pslverr and prdata.
 */
`timescale 1ns/1ps
`default_nettype none

module fcs_host_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // ****************************************
  // one apb transfer, waits for pready
  // ****************************************
  // host sets the frame pointer; device steps it after each frame access made while no save or restore runs
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released data bus shows no stale value
    pwdata  <= ~d;
  endtask : xfer
endmodule : fcs_host_model

`default_nettype wire
